// >>> core/acdp_pkg.sv
// Functional notes
// - Divide sample clock by 1 to 8
// - Register divider_sync_control selects every or first alignment
// - Accepted alignment resets divider count
// - Low sense level selects internal 1.0 V reference
// - Sense at supply selects external reference
// - Span register codes set input span
// - Stabilizer regenerates falling edge for 50% duty
// - Stabilizer need not work below 20 MHz
// - Pin or register commands power-down
// - Outputs high impedance while powered down
// - Pin low returns to normal operation
// - Power-down stops reference, bias and clock
// - Standby keeps reference powered, register only
// - Sample on rising internal clock edge
// - Alignment input synchronised before use
package acdp_pkg;
    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    localparam logic [8:0] SPAN_OFFS      = 9'h018;
    localparam logic [8:0] SYNC_CTRL_OFFS = 9'h100;
    localparam logic [8:0] DIV_CFG_OFFS   = 9'h00b;
    localparam logic [8:0] PWR_CFG_OFFS   = 9'h008;
    localparam logic [8:0] STAT_OFFS      = 9'h002;
    localparam logic [7:0] SPAN_RST       = 8'he0;
    localparam logic [7:0] SYNC_CTRL_RST  = 8'h00;
    localparam logic [7:0] DIV_CFG_RST    = 8'h00;
    localparam logic [7:0] PWR_CFG_RST    = 8'h00;
    // Sync control bits
    localparam int SYNC_EN_BIT      = 1;
    localparam int SYNC_ONESHOT_BIT = 2;
    // Divider config: ratio minus one in [2:0], stabilizer enable in [4]
    localparam int DIV_MSB          = 2;
    localparam int STAB_EN_BIT      = 4;
    // Power config: [1:0] mode
    localparam logic [1:0] PWR_NORMAL  = 2'h0;
    localparam logic [1:0] PWR_FULLDN  = 2'h1;
    localparam logic [1:0] PWR_STANDBY = 2'h2;
    // Span codes
    localparam logic [7:0] SPAN_1V00 = 8'hc0;
    localparam logic [7:0] SPAN_1V14 = 8'hc8;
    localparam logic [7:0] SPAN_1V33 = 8'hd0;
    localparam logic [7:0] SPAN_1V60 = 8'hd8;
    localparam logic [7:0] SPAN_2V00 = 8'he0;
    // Clocking
    localparam int CLK_MHZ      = 40;
    localparam int STAB_MIN_MHZ = 20;
    localparam logic [2:0] DIV_MAX_M1 = 3'h7;

    typedef enum logic [1:0] {
        ACDP_RUN     = 2'b00,
        ACDP_STANDBY = 2'b01,
        ACDP_DOWN    = 2'b11
    } acdp_pwr_t;
endpackage

// >>> core/acdp_sync2.sv
`timescale 1ns/100ps
`default_nettype none
module acdp_sync2 (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic d,
    output var  logic q
);
    logic meta_ff;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            meta_ff <= 1'b0;
            q       <= 1'b0;
        end else begin
            meta_ff <= d;
            q       <= meta_ff;
        end
    end
endmodule
`default_nettype wire

// >>> core/acdp_top.sv
`timescale 1ns/100ps
`default_nettype none
module acdp_top (
    // Clock and reset
    input  wire logic       CLK,
    input  wire logic       RST_N,
    // Pins
    input  wire logic       ALIGN_IN,
    input  wire logic       POWER_DOWN_PIN,
    input  wire logic       SENSE_LOW,
    input  wire logic       SENSE_AT_SUPPLY,
    // Register port
    input  wire logic       REG_WR,
    input  wire logic       REG_RD,
    input  wire logic [8:0] REG_ADDR,
    input  wire logic [7:0] REG_WDATA,
    output logic      [7:0] REG_RDATA,
    // Clock outputs
    output logic            CONV_CLK,
    output logic            SAMPLE_STROBE,
    output logic            DUTY_CYCLE_STABILIZER_ON,
    // Reference and span
    output logic            INT_REF_EN,
    output logic            EXT_REF_SEL,
    output logic      [7:0] SPAN_CODE,
    output logic            SPAN_VALID,
    // Power
    output logic            OUT_DRV_EN,
    output logic            BIAS_EN,
    output logic            REF_BUF_EN,
    output logic            PWR_DOWN_STAT,
    output logic            STANDBY_STAT
);
    // ----------------------------------------------------------------
    // Input synchronisers
    // ----------------------------------------------------------------
    logic align_s;
    logic pdn_s;
    logic sense_low_s;
    logic sense_sup_s;

    acdp_sync2 u_sync_align (.clk(CLK), .rst_n(RST_N), .d(ALIGN_IN),        .q(align_s));
    acdp_sync2 u_sync_pdn   (.clk(CLK), .rst_n(RST_N), .d(POWER_DOWN_PIN),  .q(pdn_s));
    acdp_sync2 u_sync_snl   (.clk(CLK), .rst_n(RST_N), .d(SENSE_LOW),       .q(sense_low_s));
    acdp_sync2 u_sync_sns   (.clk(CLK), .rst_n(RST_N), .d(SENSE_AT_SUPPLY), .q(sense_sup_s));

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    logic [7:0] span_ff;
    logic [7:0] sync_ctrl_ff;
    logic [7:0] div_cfg_ff;
    logic [7:0] pwr_cfg_ff;
    logic       armed_ff;
    logic       align_d_ff;

    wire wr_span = REG_WR && (REG_ADDR == acdp_pkg::SPAN_OFFS);
    wire wr_sync = REG_WR && (REG_ADDR == acdp_pkg::SYNC_CTRL_OFFS);
    wire wr_div  = REG_WR && (REG_ADDR == acdp_pkg::DIV_CFG_OFFS);
    wire wr_pwr  = REG_WR && (REG_ADDR == acdp_pkg::PWR_CFG_OFFS);

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            span_ff      <= acdp_pkg::SPAN_RST;
            sync_ctrl_ff <= acdp_pkg::SYNC_CTRL_RST;
            div_cfg_ff   <= acdp_pkg::DIV_CFG_RST;
            pwr_cfg_ff   <= acdp_pkg::PWR_CFG_RST;
        end else begin
            if (wr_span) span_ff <= REG_WDATA;
            if (wr_sync) sync_ctrl_ff <= REG_WDATA;
            if (wr_div)  div_cfg_ff <= REG_WDATA;
            if (wr_pwr)  pwr_cfg_ff <= REG_WDATA;
        end
    end

    // ----------------------------------------------------------------
    // Alignment acceptance
    // ----------------------------------------------------------------
    wire align_rise  = align_s && !align_d_ff;
    wire sync_en     = sync_ctrl_ff[acdp_pkg::SYNC_EN_BIT];
    wire sync_once   = sync_ctrl_ff[acdp_pkg::SYNC_ONESHOT_BIT];
    // One-shot mode: only the first pulse after the write is honoured
    wire align_take  = align_rise && sync_en && (!sync_once || armed_ff);
    // Write and accepted pulse in one cycle: the write re-arms
    wire nxt_armed   = wr_sync ? 1'b1 : (align_take ? 1'b0 : armed_ff);

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            align_d_ff <= 1'b0;
            armed_ff   <= 1'b0;
        end else begin
            align_d_ff <= align_s;
            armed_ff   <= nxt_armed;
        end
    end

    // ----------------------------------------------------------------
    // Power state
    // ----------------------------------------------------------------
    wire [1:0] pwr_mode  = pwr_cfg_ff[1:0];
    wire       want_down = pdn_s || (pwr_mode == acdp_pkg::PWR_FULLDN);
    wire       want_stby = !want_down && (pwr_mode == acdp_pkg::PWR_STANDBY);
    acdp_pkg::acdp_pwr_t pwr_ff;
    acdp_pkg::acdp_pwr_t nxt_pwr;

    always_comb begin
        case (pwr_ff)
            acdp_pkg::ACDP_RUN:     nxt_pwr = want_down ? acdp_pkg::ACDP_DOWN
                                            : (want_stby ? acdp_pkg::ACDP_STANDBY : acdp_pkg::ACDP_RUN);
            acdp_pkg::ACDP_STANDBY: nxt_pwr = want_down ? acdp_pkg::ACDP_DOWN
                                            : (want_stby ? acdp_pkg::ACDP_STANDBY : acdp_pkg::ACDP_RUN);
            acdp_pkg::ACDP_DOWN:    nxt_pwr = want_down ? acdp_pkg::ACDP_DOWN
                                            : (want_stby ? acdp_pkg::ACDP_STANDBY : acdp_pkg::ACDP_RUN);
            default:                nxt_pwr = acdp_pkg::ACDP_RUN;
        endcase
    end

    always_ff @(posedge CLK) begin
        if (!RST_N) pwr_ff <= acdp_pkg::ACDP_RUN;
        else        pwr_ff <= nxt_pwr;
    end

    wire running = (pwr_ff == acdp_pkg::ACDP_RUN);

    // ----------------------------------------------------------------
    // Clock divider
    // ----------------------------------------------------------------
    // Ratio is latched only at wrap, realignment or while stopped, so a period never tears
    logic [2:0] cnt_ff;
    logic [2:0] ratio_ff;
    logic       phase_ff;
    logic       start_ff;
    // Stabilizer enable is latched with the ratio, so no rise appears mid-period
    logic       stab_ff;
    wire  [2:0] cfg_ratio = div_cfg_ff[acdp_pkg::DIV_MSB:0];
    wire        wrap      = (cnt_ff == ratio_ff);
    wire        restart   = wrap || align_take;
    wire  [2:0] nxt_cnt   = restart ? 3'h0 : cnt_ff + 3'h1;
    wire        nxt_start = (nxt_cnt == 3'h0);
    // Widened before the add so divide by eight does not wrap to zero
    wire  [2:0] half      = 3'(({1'b0, ratio_ff} + 4'h1) >> 1);
    wire        stab_on   = div_cfg_ff[acdp_pkg::STAB_EN_BIT];
    // Stabilizer: fall at half period; without it, high one input cycle
    wire        nxt_conv  = stab_ff ? (nxt_cnt < half) || (ratio_ff == 3'h0)
                                    : (nxt_cnt == 3'h0);

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            cnt_ff   <= 3'h0;
            ratio_ff <= 3'h0;
            phase_ff <= 1'b0;
            start_ff <= 1'b0;
            stab_ff  <= 1'b0;
        end else if (!running) begin
            // Clock stopped in standby and power-down
            // Parked on the wrap count so the first period after wake is whole
            cnt_ff   <= cfg_ratio;
            ratio_ff <= cfg_ratio;
            phase_ff <= 1'b0;
            start_ff <= 1'b0;
            stab_ff  <= stab_on;
        end else begin
            cnt_ff   <= nxt_cnt;
            if (restart) ratio_ff <= cfg_ratio;
            if (restart) stab_ff <= stab_on;
            phase_ff <= nxt_conv;
            start_ff <= nxt_start;
        end
    end

    // ----------------------------------------------------------------
    // Span decode
    // ----------------------------------------------------------------
    wire span_ok = (span_ff == acdp_pkg::SPAN_1V00) || (span_ff == acdp_pkg::SPAN_1V14) ||
                   (span_ff == acdp_pkg::SPAN_1V33) || (span_ff == acdp_pkg::SPAN_1V60) ||
                   (span_ff == acdp_pkg::SPAN_2V00);

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    wire [7:0] rd_mux =
        (REG_ADDR == acdp_pkg::SPAN_OFFS)      ? span_ff :
        (REG_ADDR == acdp_pkg::SYNC_CTRL_OFFS) ? sync_ctrl_ff :
        (REG_ADDR == acdp_pkg::DIV_CFG_OFFS)   ? div_cfg_ff :
        (REG_ADDR == acdp_pkg::PWR_CFG_OFFS)   ? pwr_cfg_ff :
        (REG_ADDR == acdp_pkg::STAT_OFFS)      ? {3'h0, armed_ff, sense_sup_s, sense_low_s, pwr_ff} :
        8'h00;
    wire ext_ref = sense_sup_s;
    wire int_ref = sense_low_s && !sense_sup_s;

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            REG_RDATA                <= 8'h00;
            CONV_CLK                 <= 1'b0;
            SAMPLE_STROBE            <= 1'b0;
            DUTY_CYCLE_STABILIZER_ON <= 1'b0;
            INT_REF_EN               <= 1'b0;
            EXT_REF_SEL              <= 1'b0;
            SPAN_CODE                <= acdp_pkg::SPAN_RST;
            SPAN_VALID               <= 1'b0;
            OUT_DRV_EN               <= 1'b0;
            BIAS_EN                  <= 1'b0;
            REF_BUF_EN               <= 1'b0;
            PWR_DOWN_STAT            <= 1'b0;
            STANDBY_STAT             <= 1'b0;
        end else begin
            if (REG_RD) REG_RDATA <= rd_mux;
            CONV_CLK                 <= running && phase_ff;
            // Sampling instant is count zero; at divide by one CONV_CLK stays high
            // and the strobe fires every cycle, as no flop can toggle at CLK rate
            SAMPLE_STROBE            <= running && start_ff;
            // No rate check here: below the lock rate the duty is simply unregulated
            DUTY_CYCLE_STABILIZER_ON <= running && stab_ff;
            INT_REF_EN               <= int_ref && (pwr_ff != acdp_pkg::ACDP_DOWN);
            EXT_REF_SEL              <= ext_ref;
            SPAN_CODE                <= span_ff;
            SPAN_VALID               <= span_ok;
            OUT_DRV_EN               <= running;
            BIAS_EN                  <= running;
            // Buffer stays up in standby for the faster wake
            REF_BUF_EN               <= (pwr_ff != acdp_pkg::ACDP_DOWN);
            PWR_DOWN_STAT            <= (pwr_ff == acdp_pkg::ACDP_DOWN);
            STANDBY_STAT             <= (pwr_ff == acdp_pkg::ACDP_STANDBY);
        end
    end
endmodule
`default_nettype wire

// >>> verif/acdp_chk_sva.sv
`timescale 1ns/100ps
`default_nettype none
module acdp_chk (
    // Clock and reset
    input wire logic       CLK,
    input wire logic       RST_N,
    // Pins
    input wire logic       POWER_DOWN_PIN,
    input wire logic       SENSE_LOW,
    input wire logic       SENSE_AT_SUPPLY,
    // Outputs watched
    input wire logic       CONV_CLK,
    input wire logic       SAMPLE_STROBE,
    input wire logic       INT_REF_EN,
    input wire logic       EXT_REF_SEL,
    input wire logic [7:0] SPAN_CODE,
    input wire logic       SPAN_VALID,
    input wire logic       OUT_DRV_EN,
    input wire logic       BIAS_EN,
    input wire logic       REF_BUF_EN,
    input wire logic       PWR_DOWN_STAT,
    input wire logic       STANDBY_STAT
);
    default clocking @(posedge CLK); endclocking
    default disable iff (!RST_N);
    // ------------------------------------------------------------
    // Power
    // ------------------------------------------------------------
    // Six samples cover two sync stages, state and output flops
    pd_pin_a: assert property (POWER_DOWN_PIN[*6] |-> PWR_DOWN_STAT)
        else $error("pin high but not powered down");
    pd_hiz_a: assert property (PWR_DOWN_STAT |-> !OUT_DRV_EN)
        else $error("drivers enabled in power-down");
    pd_off_a: assert property (PWR_DOWN_STAT |-> !(CONV_CLK || BIAS_EN || REF_BUF_EN))
        else $error("clock, bias or buffer alive in power-down");
    sb_ref_a: assert property (STANDBY_STAT |-> REF_BUF_EN && !BIAS_EN && !CONV_CLK)
        else $error("standby power split wrong");
    // ------------------------------------------------------------
    // Reference, span and sampling
    // ------------------------------------------------------------
    span_ok_a: assert property ($past(RST_N) |-> SPAN_VALID == (SPAN_CODE inside {8'hc0, 8'hc8, 8'hd0, 8'hd8, 8'he0}))
        else $error("span valid flag disagrees with code");
    ext_ref_a: assert property (SENSE_AT_SUPPLY[*6] |-> EXT_REF_SEL && !INT_REF_EN)
        else $error("external reference not chosen");
    int_ref_a: assert property ((SENSE_LOW && !SENSE_AT_SUPPLY && !PWR_DOWN_STAT)[*6] |-> INT_REF_EN)
        else $error("internal reference not chosen");
    strobe_rise_a: assert property ($rose(CONV_CLK) |-> SAMPLE_STROBE)
        else $error("no sample strobe on clock rise");
endmodule
bind acdp_top acdp_chk u_chk (.CLK, .RST_N, .POWER_DOWN_PIN, .SENSE_LOW, .SENSE_AT_SUPPLY, .CONV_CLK,
    .SAMPLE_STROBE, .INT_REF_EN, .EXT_REF_SEL, .SPAN_CODE, .SPAN_VALID, .OUT_DRV_EN, .BIAS_EN,
    .REF_BUF_EN, .PWR_DOWN_STAT, .STANDBY_STAT);
`default_nettype wire

// >>> verif/acdp_sense_src.sv
`timescale 1ns/100ps
`default_nettype none
// Board side of the sense pin: level in millivolts to comparator flags
module acdp_sense_src #(parameter int SUPPLY_MV = 1800) (
    input  wire logic [11:0] sense_mv,
    output logic             sense_low,
    output logic             sense_sup
);
    assign sense_low = sense_mv <= 12'h0c8;
    assign sense_sup = sense_mv >= 12'(SUPPLY_MV);
endmodule
`default_nettype wire

// >>> verif/test_adc_clock_divider_power_ctrl.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin fail_count++; \
    $display("[ERR] %0t got %h exp %h", $time, (a), (e)); end end
module test_adc_clock_divider_power_ctrl;
    logic       clk = 1'b0, rst_n = 1'b0, align = 1'b0, pdp = 1'b0, wr = 1'b0, rd = 1'b0;
    logic [8:0] addr = 9'h000;
    logic [7:0] wdata = 8'h00, rdata, d, span_code;
    logic [11:0] sense_mv = 12'h000;
    logic       s_low, s_sup, conv_clk, strobe, stab_on, int_ref, ext_ref, span_valid;
    logic       drv_en, bias_en, rbuf_en, pd_stat, sb_stat;
    int         check_count = 0, fail_count = 0, n, h, i;
    // Stabilizer relock wait: 1.5 us of 25 ns cycles
    localparam int RELOCK_CYC = 60;
    // Rows: {expected valid flag, span code}
    logic [8:0] rows [6] = '{9'h1c0, 9'h1c8, 9'h1d0, 9'h1d8, 9'h1e0, 9'h055};

    always #12.5 clk = ~clk;

    acdp_sense_src u_sense (.sense_mv(sense_mv), .sense_low(s_low), .sense_sup(s_sup));
    acdp_top DUT (.CLK(clk), .RST_N(rst_n), .ALIGN_IN(align), .POWER_DOWN_PIN(pdp), .SENSE_LOW(s_low),
        .SENSE_AT_SUPPLY(s_sup), .REG_WR(wr), .REG_RD(rd), .REG_ADDR(addr), .REG_WDATA(wdata),
        .REG_RDATA(rdata), .CONV_CLK(conv_clk), .SAMPLE_STROBE(strobe), .DUTY_CYCLE_STABILIZER_ON(stab_on),
        .INT_REF_EN(int_ref), .EXT_REF_SEL(ext_ref), .SPAN_CODE(span_code), .SPAN_VALID(span_valid),
        .OUT_DRV_EN(drv_en), .BIAS_EN(bias_en), .REF_BUF_EN(rbuf_en), .PWR_DOWN_STAT(pd_stat),
        .STANDBY_STAT(sb_stat));

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic wr_reg(input logic [8:0] a, input logic [7:0] v);
        @(negedge clk);
        wr = 1'b1; addr = a; wdata = v;
        @(negedge clk);
        wr = 1'b0;
    endtask
    task automatic rd_reg(input logic [8:0] a);
        @(negedge clk);
        rd = 1'b1; addr = a;
        @(negedge clk);
        rd = 1'b0; d = rdata;
    endtask
    // Period n and high count h of the conversion clock, strobe to strobe
    task automatic period();
        i = 0;
        while (strobe !== 1'b1 && i < 40) begin @(negedge clk); i++; end
        n = 0; h = 0;
        do begin h += conv_clk; @(negedge clk); n++; end while (strobe !== 1'b1 && n < 40);
    endtask
    // Strobe lands three edges after the edge that first sees the pulse
    task automatic align_chk(input logic e);
        @(negedge clk);
        align = 1'b1;
        repeat (4) @(negedge clk);
        `CHK(strobe, e)
        align = 1'b0;
        repeat (3) @(negedge clk);
    endtask
    task automatic print_verdict();
        $display("Checks %0d, mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    initial begin
        repeat (5000) @(posedge clk);
        fail_count++;
        print_verdict();
    end

    initial begin
        repeat (8) @(negedge clk);
        `CHK(span_code, acdp_pkg::SPAN_RST)
        rst_n = 1'b1;
        rd_reg(acdp_pkg::SYNC_CTRL_OFFS);
        `CHK(d, acdp_pkg::SYNC_CTRL_RST)
        rd_reg(9'h1ff);
        `CHK(d, 8'h00)
        foreach (rows[k]) begin
            wr_reg(acdp_pkg::SPAN_OFFS, rows[k][7:0]);
            @(negedge clk);
            `CHK({span_valid, span_code}, rows[k])
            rd_reg(acdp_pkg::SPAN_OFFS);
            `CHK(d, rows[k][7:0])
        end
        for (int k = 0; k < 8; k++) begin
            wr_reg(acdp_pkg::DIV_CFG_OFFS, 8'(k));
            repeat (20) @(negedge clk);
            period();
            `CHK(n, k + 1)
            `CHK(h, 1)
        end
        // Divide by 8 and by 7 with the stabilizer: high for the lower half
        wr_reg(acdp_pkg::DIV_CFG_OFFS, 8'h17);
        repeat (RELOCK_CYC) @(negedge clk);
        period();
        `CHK(h, 4)
        `CHK(n, 8)
        // Divide by 7 is a ratio where the stabilizer is wanted
        wr_reg(acdp_pkg::DIV_CFG_OFFS, 8'h16);
        repeat (RELOCK_CYC) @(negedge clk);
        period();
        `CHK(stab_on, 1'b1)
        `CHK(h, 3)
        `CHK(n, 7)
        wr_reg(acdp_pkg::SYNC_CTRL_OFFS, 8'h02);
        align_chk(1'b1);
        align_chk(1'b1);
        wr_reg(acdp_pkg::SYNC_CTRL_OFFS, 8'h06);
        align_chk(1'b1);
        align_chk(1'b0);
        sense_mv = 12'h708;
        repeat (6) @(negedge clk);
        `CHK({ext_ref, int_ref}, 2'b10)
        sense_mv = 12'h064;
        repeat (6) @(negedge clk);
        `CHK({ext_ref, int_ref}, 2'b01)
        rd_reg(acdp_pkg::STAT_OFFS);
        `CHK(d, 8'h04)
        pdp = 1'b1;
        repeat (6) @(negedge clk);
        `CHK({pd_stat, drv_en, bias_en, rbuf_en, conv_clk}, 5'b10000)
        pdp = 1'b0;
        repeat (6) @(negedge clk);
        `CHK({pd_stat, drv_en, bias_en}, 3'b011)
        wr_reg(acdp_pkg::PWR_CFG_OFFS, {6'h00, acdp_pkg::PWR_FULLDN});
        repeat (3) @(negedge clk);
        `CHK({pd_stat, drv_en}, 2'b10)
        wr_reg(acdp_pkg::PWR_CFG_OFFS, {6'h00, acdp_pkg::PWR_STANDBY});
        repeat (3) @(negedge clk);
        `CHK({sb_stat, pd_stat, rbuf_en, int_ref, bias_en, drv_en}, 6'b101100)
        wr_reg(acdp_pkg::PWR_CFG_OFFS, {6'h00, acdp_pkg::PWR_NORMAL});
        repeat (3) @(negedge clk);
        `CHK({sb_stat, drv_en}, 2'b01)
        // Reset again in mid-run: registers and outputs return to reset values
        rst_n = 1'b0;
        repeat (2) @(negedge clk);
        `CHK({span_code, span_valid, drv_en}, {acdp_pkg::SPAN_RST, 2'b00})
        rst_n = 1'b1;
        repeat (3) @(negedge clk);
        `CHK({span_code, span_valid, drv_en}, {acdp_pkg::SPAN_RST, 2'b11})
        print_verdict();
    end
endmodule
`default_nettype wire
